// ### core/pbcl_pkg.sv
`default_nettype none

package pbcl_pkg;

  // ***************************************************
  // clock and timing
  // ***************************************************
  localparam int CLK_MHZ = 20;
  localparam int STRETCH_US = 256;
  localparam int STRETCH_CYCLES = STRETCH_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ***************************************************
  // register bus and register indices
  // ***************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_MSCTL = 5'h09;
  localparam logic [4:0] REG_SPMODES = 5'h12;
  localparam logic [4:0] REG_EXTMODE = 5'h13;
  localparam logic [4:0] REG_PWRSTAT = 5'h1A;
  localparam logic [4:0] REG_INDIC = 5'h1B;
  localparam logic [4:0] REG_CAPTURE = 5'h1F;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int CTRL_SOFTRST_BIT = 15;
  localparam int CTRL_SPDLSB_BIT = 13;
  localparam int CTRL_ANEN_BIT = 12;
  localparam int CTRL_PWRDN_BIT = 11;
  localparam int CTRL_SPDMSB_BIT = 6;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ADV_ABIL_LSB = 5;
  localparam int MSCTL_LSB = 8;
  localparam int SPM_ADDR_LSB = 0;
  localparam int MODE_LSB = 11;
  localparam int DELAY_LSB = 8;
  localparam int CAPT_LEVEL_LSB = 4;
  localparam int STRAP_REFCLK = 0;
  localparam int STRAP_PLLOPT = 1;
  localparam int STRAP_DELAY = 2;
  localparam int NUM_STRAPS = 3;
  localparam int NUM_CFG = 4;

  // ***************************************************
  // reset values and write masks
  // ***************************************************
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADV_RESET = 16'h0000;
  localparam logic [15:0] MSCTL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hB940;
  localparam logic [15:0] ADV_WMASK = 16'h05E0;
  localparam logic [15:0] MSCTL_WMASK = 16'h1F00;
  localparam logic [1:0] DELAY_ON = 2'h3;
  localparam logic [1:0] DELAY_OFF = 2'h0;

  // ***************************************************
  // pin level values and operating modes
  // ***************************************************
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_VDD = 2'h3;
  localparam logic [3:0] PAT_GND = 4'h0;
  localparam logic [3:0] PAT_MID = 4'hA;
  localparam logic [3:0] PAT_HIGH = 4'hC;
  localparam logic [3:0] PAT_VDD = 4'hF;
  localparam logic [1:0] MODE_SEL_LEVEL = LVL_HIGH;
  localparam logic [4:0] MODE_SINGLE = 5'h17;
  localparam logic [4:0] MODE_MULTI = 5'h18;
  localparam logic [4:0] MODE_SLAVE = 5'h19;
  localparam logic [4:0] MODE_MASTER = 5'h1A;
  localparam logic [4:0] MODE_NONE = 5'h00;
  localparam logic [4:0] MS_SINGLE = 5'h03;
  localparam logic [4:0] MS_MULTI = 5'h0F;
  localparam logic [4:0] MS_SLAVE = 5'h13;
  localparam logic [4:0] MS_MASTER = 5'h1F;
  localparam logic [3:0] ADV_MODE_ABIL = 4'hF;
  localparam logic MODE_SPDLSB = 1'b0;
  localparam logic MODE_ANEN = 1'b1;
  localparam logic MODE_SPDMSB = 1'b1;

  typedef enum logic [2:0] {
    seq_run = 3'b001,
    seq_soft = 3'b010,
    seq_pdrst = 3'b100
  } pbcl_seq_type;

endpackage

`default_nettype wire

// ### core/pbcl_level_resolver.sv
`default_nettype none

module pbcl_level_resolver #(
  parameter int PINS = 4
) (
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic [1:0] phase_i,
  input wire logic [PINS-1:0] pin_i,
  output logic [2*PINS-1:0] level_o
);

  logic [3:0] hist [PINS];
  logic [3:0] next_hist [PINS];

  // ***************************************************
  // classify one pin over the four led phases
  // ***************************************************
  function automatic logic [1:0] classify(input logic [3:0] pat);
    logic [1:0] lvl;
    case (pat)
      pbcl_pkg::PAT_VDD: lvl = pbcl_pkg::LVL_VDD;
      pbcl_pkg::PAT_MID: lvl = pbcl_pkg::LVL_MID;
      pbcl_pkg::PAT_HIGH: lvl = pbcl_pkg::LVL_HIGH;
      default: lvl = pbcl_pkg::LVL_GND;
    endcase
    return lvl;
  endfunction

  // samples are filed by phase so the pattern lines up with the led drive
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      next_hist[p] = hist[p];
      if (sample_i) begin
        next_hist[p][phase_i] = pin_i[p];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int p = 0; p < PINS; p++) begin
      hist[p] <= next_hist[p];
    end
  end

  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      level_o[2*p +: 2] = classify(hist[p]);
    end
  end

endmodule

`default_nettype wire

// ### core/pbcl_mode_decoder.sv
`default_nettype none

module pbcl_mode_decoder (
  input wire logic [1:0] sel_level_i,
  input wire logic [1:0] mode_level_i,
  output logic [4:0] mode_o,
  output logic valid_o,
  output logic [4:0] ms_o
);

  always_comb begin
    mode_o = pbcl_pkg::MODE_NONE;
    if (sel_level_i == pbcl_pkg::MODE_SEL_LEVEL) begin
      case (mode_level_i)
        pbcl_pkg::LVL_GND: mode_o = pbcl_pkg::MODE_SINGLE;
        pbcl_pkg::LVL_MID: mode_o = pbcl_pkg::MODE_MULTI;
        pbcl_pkg::LVL_HIGH: mode_o = pbcl_pkg::MODE_SLAVE;
        default: mode_o = pbcl_pkg::MODE_MASTER;
      endcase
    end
  end

  always_comb begin
    valid_o = 1'b1;
    case (mode_o)
      pbcl_pkg::MODE_SINGLE: ms_o = pbcl_pkg::MS_SINGLE;
      pbcl_pkg::MODE_MULTI: ms_o = pbcl_pkg::MS_MULTI;
      pbcl_pkg::MODE_SLAVE: ms_o = pbcl_pkg::MS_SLAVE;
      pbcl_pkg::MODE_MASTER: ms_o = pbcl_pkg::MS_MASTER;
      default: begin
        // reserved codes seed nothing
        valid_o = 1'b0;
        ms_o = 5'h00;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### core/pbcl_config_latch.sv
`default_nettype none

module pbcl_config_latch #(
  parameter int STRETCH_CYCLES = pbcl_pkg::STRETCH_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] strap_in_i,
  input wire logic [2:0] strap_func_i,
  output logic [2:0] strap_out_o,
  output logic [2:0] strap_oe_o,
  input wire logic [3:0] cfg_pin_i,
  input wire logic link_led_mid_i,
  input wire logic link_led_high_i,
  output logic led_speed_mid_o,
  output logic led_speed_high_o,
  input wire logic hw_powerdown_pin_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  output logic refclk_freq_select_o,
  output logic powerdown_o,
  output logic pll_enable_o,
  output logic internal_reset_o,
  output logic [4:0] station_address_o,
  output logic [1:0] rgmii_delay_o
);

  // ***************************************************
  // declarations
  // ***************************************************
  logic in_reset;
  logic load;
  logic [1:0] phase;
  logic [2:0] straps_q;
  logic [7:0] levels_q;
  logic next_in_reset;
  logic next_load;
  logic [1:0] next_phase;
  logic [2:0] next_straps_q;
  logic [7:0] next_levels_q;
  logic capture;
  logic [7:0] levels_now;

  logic [2:0] next_strap_out_o;
  logic [2:0] next_strap_oe_o;
  logic next_led_mid;
  logic next_led_high;

  logic [15:0] ctrl;
  logic [15:0] adv;
  logic [15:0] msctl;
  logic [4:0] station_address;
  logic [4:0] operating_mode_field;
  logic [1:0] rgmii_delay;
  logic [15:0] next_ctrl;
  logic [15:0] next_adv;
  logic [15:0] next_msctl;
  logic [4:0] next_station_address;
  logic [4:0] next_operating_mode_field;
  logic [1:0] next_rgmii_delay;
  logic [4:0] dec_mode;
  logic dec_valid;
  logic [4:0] dec_ms;

  pbcl_pkg::pbcl_seq_type seq;
  pbcl_pkg::pbcl_seq_type next_seq;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic pd_q;
  logic next_pd_q;
  logic pll_off;
  logic next_pll_off;
  logic pd_now;
  logic soft_req;
  logic next_refclk;
  logic next_powerdown;
  logic next_pll_enable;
  logic next_internal_reset;

  logic [15:0] next_rdata;

  localparam logic [15:0] STRETCH_LAST = 16'(STRETCH_CYCLES - 1);

  // ***************************************************
  // field helper
  // ***************************************************
  function automatic logic [15:0] masked_write(input logic [15:0] old,
                                               input logic [15:0] wd,
                                               input logic [15:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction

  // ***************************************************
  // capture of straps and configuration pins
  // ***************************************************
  pbcl_level_resolver #(
    .PINS(pbcl_pkg::NUM_CFG)
  ) u_resolver (
    .clk_i(clk_i),
    .sample_i(reset_i),
    .phase_i(phase),
    .pin_i(cfg_pin_i),
    .level_o(levels_now)
  );

  // capture happens on the first edge after release, while pins still float
  assign capture = in_reset & ~reset_i;

  always_comb begin
    next_in_reset = reset_i;
    next_load = capture;
    // gated on in_reset so the probe phase is known from the first reset edge
    next_phase = 2'h0;
    if (reset_i && in_reset) begin
      next_phase = phase + 2'h1;
    end
    next_straps_q = straps_q;
    next_levels_q = levels_q;
    if (capture) begin
      next_straps_q = strap_in_i;
      next_levels_q = levels_now;
    end
  end

  // only hardware reset release updates the captures
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      in_reset <= 1'b1;
      load <= 1'b0;
      phase <= next_phase;
    end else begin
      in_reset <= next_in_reset;
      load <= next_load;
      phase <= next_phase;
      straps_q <= next_straps_q;
      levels_q <= next_levels_q;
    end
  end

  // ***************************************************
  // shared pins: straps float and leds probe during reset
  // ***************************************************
  always_comb begin
    next_strap_oe_o = (reset_i || in_reset) ? 3'h0 : 3'h7;
    next_strap_out_o = strap_func_i;
    // during reset the leds walk a pattern the resolver recognises
    next_led_mid = reset_i ? next_phase[0] : link_led_mid_i;
    next_led_high = reset_i ? next_phase[1] : link_led_high_i;
  end

  always_ff @(posedge clk_i) begin
    led_speed_mid_o <= next_led_mid;
    led_speed_high_o <= next_led_high;
    if (reset_i) begin
      strap_oe_o <= 3'h0;
      strap_out_o <= 3'h0;
    end else begin
      strap_oe_o <= next_strap_oe_o;
      strap_out_o <= next_strap_out_o;
    end
  end

  // ***************************************************
  // register file
  // ***************************************************
  pbcl_mode_decoder u_mode (
    .sel_level_i(levels_q[7:6]),
    .mode_level_i(levels_q[5:4]),
    .mode_o(dec_mode),
    .valid_o(dec_valid),
    .ms_o(dec_ms)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_adv = adv;
    next_msctl = msctl;
    next_station_address = station_address;
    next_operating_mode_field = operating_mode_field;
    next_rgmii_delay = rgmii_delay;
    if (load) begin
      // decoders see only the held captures, never the live pins
      next_station_address = {2'h0, levels_q[2], levels_q[1:0]};
      next_adv[pbcl_pkg::ADV_PAUSE_BIT] = levels_q[3];
      next_rgmii_delay = straps_q[pbcl_pkg::STRAP_DELAY] ?
                         pbcl_pkg::DELAY_ON : pbcl_pkg::DELAY_OFF;
      next_operating_mode_field = dec_mode;
      if (dec_valid) begin
        // duplex bit is left at its ordinary default, same for every mode
        next_ctrl[pbcl_pkg::CTRL_SPDLSB_BIT] = pbcl_pkg::MODE_SPDLSB;
        next_ctrl[pbcl_pkg::CTRL_ANEN_BIT] = pbcl_pkg::MODE_ANEN;
        next_ctrl[pbcl_pkg::CTRL_SPDMSB_BIT] = pbcl_pkg::MODE_SPDMSB;
        next_adv[pbcl_pkg::ADV_ABIL_LSB +: 4] = pbcl_pkg::ADV_MODE_ABIL;
        next_msctl[pbcl_pkg::MSCTL_LSB +: 5] = dec_ms;
      end
    end else if (reg_write_i) begin
      // a mode write is stored only; nothing is re-derived from it
      case (reg_addr_i)
        pbcl_pkg::REG_CTRL: begin
          next_ctrl = masked_write(ctrl, reg_wdata_i, pbcl_pkg::CTRL_WMASK);
          next_ctrl[pbcl_pkg::CTRL_SOFTRST_BIT] = 1'b0;
        end
        pbcl_pkg::REG_ADV: next_adv = masked_write(adv, reg_wdata_i, pbcl_pkg::ADV_WMASK);
        pbcl_pkg::REG_MSCTL: next_msctl = masked_write(msctl, reg_wdata_i, pbcl_pkg::MSCTL_WMASK);
        pbcl_pkg::REG_SPMODES: next_station_address = reg_wdata_i[4:0];
        pbcl_pkg::REG_EXTMODE: next_operating_mode_field = reg_wdata_i[15:11];
        pbcl_pkg::REG_INDIC: next_rgmii_delay = reg_wdata_i[9:8];
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // software reset leaves all of these untouched
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= pbcl_pkg::CTRL_RESET;
      adv <= pbcl_pkg::ADV_RESET;
      msctl <= pbcl_pkg::MSCTL_RESET;
      station_address <= 5'h00;
      operating_mode_field <= pbcl_pkg::MODE_NONE;
      rgmii_delay <= pbcl_pkg::DELAY_OFF;
    end else begin
      ctrl <= next_ctrl;
      adv <= next_adv;
      msctl <= next_msctl;
      station_address <= next_station_address;
      operating_mode_field <= next_operating_mode_field;
      rgmii_delay <= next_rgmii_delay;
    end
  end

  // ***************************************************
  // power-down and internal reset sequencing
  // ***************************************************
  assign pd_now = hw_powerdown_pin_i | ctrl[pbcl_pkg::CTRL_PWRDN_BIT];
  assign soft_req = reg_write_i && !load && (reg_addr_i == pbcl_pkg::REG_CTRL)
                    && reg_wdata_i[pbcl_pkg::CTRL_SOFTRST_BIT];

  always_comb begin
    next_seq = seq;
    next_cnt = cnt;
    next_pd_q = pd_now;
    next_pll_off = pll_off;
    case (seq)
      pbcl_pkg::seq_run: begin
        next_cnt = 16'h0000;
        if (soft_req) begin
          next_seq = pbcl_pkg::seq_soft;
        end else if (pd_q && !pd_now) begin
          // stretch lets the pll settle; captures are not touched
          next_seq = pbcl_pkg::seq_pdrst;
        end
      end
      pbcl_pkg::seq_soft, pbcl_pkg::seq_pdrst: begin
        next_cnt = cnt + 16'h0001;
        if (cnt == STRETCH_LAST) begin
          next_seq = pbcl_pkg::seq_run;
          next_cnt = 16'h0000;
          if (seq == pbcl_pkg::seq_soft) begin
            next_pll_off = 1'b0;
          end
        end
      end
      default: begin
        next_seq = pbcl_pkg::seq_run;
        next_cnt = 16'h0000;
      end
    endcase
    // a shut pll needs a software or hardware reset to restart; a new request wins
    if (hw_powerdown_pin_i && !straps_q[pbcl_pkg::STRAP_PLLOPT]) begin
      next_pll_off = 1'b1;
    end
    next_refclk = straps_q[pbcl_pkg::STRAP_REFCLK];
    next_powerdown = pd_now;
    next_pll_enable = !next_pll_off;
    next_internal_reset = (next_seq != pbcl_pkg::seq_run);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seq <= pbcl_pkg::seq_run;
      cnt <= 16'h0000;
      pd_q <= 1'b0;
      pll_off <= 1'b0;
      refclk_freq_select_o <= 1'b0;
      powerdown_o <= 1'b0;
      pll_enable_o <= 1'b1;
      internal_reset_o <= 1'b0;
    end else begin
      seq <= next_seq;
      cnt <= next_cnt;
      pd_q <= next_pd_q;
      pll_off <= next_pll_off;
      refclk_freq_select_o <= next_refclk;
      powerdown_o <= next_powerdown;
      pll_enable_o <= next_pll_enable;
      internal_reset_o <= next_internal_reset;
    end
  end

  // ***************************************************
  // read port and mirrored outputs
  // ***************************************************
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_read_i) begin
      case (reg_addr_i)
        pbcl_pkg::REG_CTRL: begin
          next_rdata = ctrl;
          next_rdata[pbcl_pkg::CTRL_SOFTRST_BIT] = (seq == pbcl_pkg::seq_soft);
        end
        pbcl_pkg::REG_ADV: next_rdata = adv;
        pbcl_pkg::REG_MSCTL: next_rdata = msctl;
        pbcl_pkg::REG_SPMODES: next_rdata[4:0] = station_address;
        pbcl_pkg::REG_EXTMODE: next_rdata[15:11] = operating_mode_field;
        pbcl_pkg::REG_INDIC: next_rdata[9:8] = rgmii_delay;
        pbcl_pkg::REG_PWRSTAT: next_rdata[3:0] = {hw_powerdown_pin_i, internal_reset_o,
                                                 pll_off, powerdown_o};
        pbcl_pkg::REG_CAPTURE: next_rdata[11:0] = {levels_q, 1'b0, straps_q};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
      station_address_o <= 5'h00;
      rgmii_delay_o <= pbcl_pkg::DELAY_OFF;
    end else begin
      reg_rdata_o <= next_rdata;
      station_address_o <= next_station_address;
      rgmii_delay_o <= next_rgmii_delay;
    end
  end

endmodule

`default_nettype wire

// ### tb/pbcl_board.sv
`default_nettype none

module pbcl_board (
  input wire logic [2:0] pull_i,
  input wire logic [7:0] sel_i,
  input wire logic [2:0] strap_out_i,
  input wire logic [2:0] strap_oe_i,
  input wire logic led_mid_i,
  input wire logic led_high_i,
  output logic [2:0] strap_pin_o,
  output logic [3:0] cfg_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************
  // strap resistors and configuration wiring
  // ***************************************************
  // a released strap falls back to its resistor level
  assign strap_pin_o = (strap_oe_i & strap_out_i) | (~strap_oe_i & pull_i);
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      case (sel_i[2*k+:2])
        2'h0: cfg_pin_o[k] = 1'b0;
        2'h1: cfg_pin_o[k] = led_mid_i;
        2'h2: cfg_pin_o[k] = led_high_i;
        default: cfg_pin_o[k] = 1'b1;
      endcase
    end
  end
endmodule

`default_nettype wire

// ### tb/pbcl_chk.sv
`default_nettype none

module pbcl_chk #(
  parameter int STRETCH_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] strap_in_i,
  input wire logic [2:0] strap_func_i,
  input wire logic [2:0] strap_out_o,
  input wire logic [2:0] strap_oe_o,
  input wire logic hw_powerdown_pin_i,
  input wire logic reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic refclk_freq_select_o,
  input wire logic powerdown_o,
  input wire logic internal_reset_o,
  input wire logic [1:0] rgmii_delay_o
);
  int run_len;
  logic rst_q;
  logic [2:0] cap;
  // ***************************************************
  // helper state
  // ***************************************************
  always_ff @(posedge clk_i) begin
    rst_q <= reset_i;
    run_len <= (internal_reset_o && !reset_i) ? run_len + 1 : 0;
    if (rst_q && !reset_i) begin
      cap <= strap_in_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ***************************************************
  // properties
  // ***************************************************
  a_oe_after_release: assert property ($changed(strap_oe_o) |-> strap_oe_o == 3'h7
    && $past(reset_i, 3) && !$past(reset_i, 2)) else $error("strap enable moved off release");
  a_strap_out_copy: assert property (!reset_i |=> strap_out_o == $past(strap_func_i))
    else $error("strap output not one cycle copy");
  a_refclk_capture: assert property ($fell(reset_i) |-> ##3
    refclk_freq_select_o == cap[0]) else $error("refclk select not captured strap");
  a_delay_capture: assert property ($fell(reset_i) |-> ##3 rgmii_delay_o == {2{cap[2]}})
    else $error("delay enables not captured strap");
  a_capture_held: assert property ($changed(refclk_freq_select_o)
    |-> $past(reset_i, 3) || $past(reset_i, 4)) else $error("refclk select changed late");
  a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  a_pin_powers_down: assert property (hw_powerdown_pin_i |=> powerdown_o)
    else $error("power-down pin ignored");
  a_exit_reset: assert property ($fell(powerdown_o) |-> ##[0:2] internal_reset_o)
    else $error("no internal reset after power-down");
  a_stretch_bound: assert property (run_len <= STRETCH_CYCLES)
    else $error("internal reset too long");
endmodule

bind pbcl_config_latch pbcl_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) pbcl_chk_inst (
  .clk_i, .reset_i, .strap_in_i, .strap_func_i, .strap_out_o, .strap_oe_o,
  .hw_powerdown_pin_i, .reg_read_i, .reg_rdata_o, .refclk_freq_select_o, .powerdown_o,
  .internal_reset_o, .rgmii_delay_o);

`default_nettype wire

// ### tb/pbcl_config_latch_tb.sv
`default_nettype none

module pbcl_config_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STR = 8;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hw_powerdown_pin_i = 1'b0;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic link_led_mid_i = 1'b0;
  logic link_led_high_i = 1'b1;
  logic [2:0] strap_func_i = 3'h5;
  logic [2:0] pull = 3'h0;
  logic [7:0] sel = 8'h00;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [2:0] strap_in_i, strap_out_o, strap_oe_o;
  logic [3:0] cfg_pin_i;
  logic led_speed_mid_o, led_speed_high_o, refclk_freq_select_o, powerdown_o, pll_enable_o;
  logic internal_reset_o;
  logic [15:0] reg_rdata_o;
  logic [4:0] station_address_o;
  logic [1:0] rgmii_delay_o;
  // pulls in 10:8, pin levels pin k at 2k
  logic [10:0] cfgs [5] = '{11'h080, 11'h795, 11'h5AA, 11'h2BF, 11'h01B};
  int err_total = 0;
  int num_checks = 0;
  int n;

  always #25 clk_i = ~clk_i;

  pbcl_config_latch #(.STRETCH_CYCLES(STR)) pbcl_config_latch_inst (
    .clk_i, .reset_i, .strap_in_i, .strap_func_i, .strap_out_o, .strap_oe_o, .cfg_pin_i,
    .link_led_mid_i, .link_led_high_i, .led_speed_mid_o, .led_speed_high_o,
    .hw_powerdown_pin_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .refclk_freq_select_o, .powerdown_o, .pll_enable_o, .internal_reset_o,
    .station_address_o, .rgmii_delay_o);

  pbcl_board pbcl_board_inst (.pull_i(pull), .sel_i(sel), .strap_out_i(strap_out_o),
    .strap_oe_i(strap_oe_o), .led_mid_i(led_speed_mid_o), .led_high_i(led_speed_high_o),
    .strap_pin_o(strap_in_i), .cfg_pin_o(cfg_pin_i));

  // ***************************************************
  // tasks
  // ***************************************************
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata_o);
  endtask

  task automatic do_reset(input logic [10:0] c, input logic p);
    @(posedge clk_i);
    pull <= c[10:8];
    sel <= c[7:0];
    hw_powerdown_pin_i <= p;
    reset_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("oe_in_reset", 16'h0000, {13'h0, strap_oe_o});
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("oe_run", 16'h0007, {13'h0, strap_oe_o});
  endtask

  // waits for internal reset, then counts the cycles it stays high
  task automatic stretch(output int len);
    int t;
    len = 0;
    t = 0;
    #1;
    while (internal_reset_o !== 1'b1 && t < 50) begin
      @(posedge clk_i);
      #1;
      t++;
    end
    while (internal_reset_o === 1'b1 && len < 100) begin
      @(posedge clk_i);
      #1;
      len++;
    end
  endtask

  task automatic check_all(input logic [2:0] s, input logic [7:0] v);
    logic [1:0] l0;
    logic [1:0] l1;
    logic [1:0] l2;
    logic ok;
    l0 = v[1:0];
    l1 = v[3:2];
    l2 = v[5:4];
    ok = (v[7:6] == 2'h2);
    rd(5'h1F, {4'h0, v, 1'b0, s});
    rd(5'h12, {13'h0, (l1 == 2'h1 || l1 == 2'h3), l0});
    rd(5'h13, {ok ? 5'h17 + 5'(l2) : 5'h00, 11'h0});
    rd(5'h04, {5'h0, l1[1], 1'b0, ok ? 4'hF : 4'h0, 5'h0});
    rd(5'h09, {3'h0, ok ? {l2, l2[0], 2'h3} : 5'h00, 8'h0});
    rd(5'h00, ok ? 16'h1040 : 16'h0000);
    rd(5'h1B, {6'h0, {2{s[2]}}, 8'h0});
    chk("refclk", {15'h0, s[0]}, {15'h0, refclk_freq_select_o});
    chk("delay", {14'h0, {2{s[2]}}}, {14'h0, rgmii_delay_o});
    chk("address", {13'h0, (l1 == 2'h1 || l1 == 2'h3), l0}, {11'h0, station_address_o});
  endtask

  // ***************************************************
  // sequence
  // ***************************************************
  initial begin
    foreach (cfgs[i]) begin
      do_reset(cfgs[i], 1'b0);
      check_all(cfgs[i][10:8], cfgs[i][7:0]);
    end
    do_reset(cfgs[0], 1'b0);
    wr(5'h13, 16'hC000);
    rd(5'h13, 16'hC000);
    rd(5'h09, 16'h0300);
    wr(5'h12, 16'h0015);
    rd(5'h12, 16'h0015);
    chk("address", 16'h0015, {11'h0, station_address_o});
    rd(5'h05, 16'h0000);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    @(posedge clk_i);
    hw_powerdown_pin_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("powerdown", 16'h0001, {15'h0, powerdown_o});
    chk("pll", 16'h0000, {15'h0, pll_enable_o});
    rd(5'h1A, 16'h000B);
    rd(5'h12, 16'h0015);
    @(posedge clk_i);
    hw_powerdown_pin_i <= 1'b0;
    stretch(n);
    chk("pd_stretch", 16'(STR), 16'(n));
    chk("pll", 16'h0000, {15'h0, pll_enable_o});
    rd(5'h1F, 16'h0800);
    @(posedge clk_i);
    sel <= 8'h1B;
    pull <= 3'h7;
    wr(5'h00, 16'h9040);
    stretch(n);
    chk("soft_stretch", 16'(STR), 16'(n));
    chk("pll", 16'h0001, {15'h0, pll_enable_o});
    rd(5'h1F, 16'h0800);
    rd(5'h13, 16'hC000);
    rd(5'h00, 16'h1040);
    wr(5'h04, 16'hFFFF);
    rd(5'h04, 16'h05E0);
    wr(5'h09, 16'hFFFF);
    rd(5'h09, 16'h1F00);
    wr(5'h00, 16'h0800);
    @(posedge clk_i);
    #1;
    chk("ctrl_powerdown", 16'h0001, {15'h0, powerdown_o});
    wr(5'h00, 16'h0000);
    stretch(n);
    chk("ctrl_pd_stretch", 16'(STR), 16'(n));
    do_reset(cfgs[1], 1'b0);
    @(posedge clk_i);
    hw_powerdown_pin_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("pll", 16'h0001, {15'h0, pll_enable_o});
    do_reset(cfgs[0], 1'b1);
    chk("powerdown", 16'h0001, {15'h0, powerdown_o});
    results();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
endmodule

`default_nettype wire
